// [ddrim_pkg.sv]
package ddrim_pkg;

  localparam int ADDR_W       = 13;
  localparam int BA_W         = 3;
  localparam int COL_W        = 3;
  localparam int MR_COUNT     = 4;
  localparam int BURST_BEATS  = 8;
  localparam int CHOP_BEATS   = 4;

  localparam logic [1:0] MR0_IDX = 2'h0;
  localparam logic [1:0] MR1_IDX = 2'h1;
  localparam logic [1:0] MR2_IDX = 2'h2;
  localparam logic [1:0] MR3_IDX = 2'h3;

  localparam int BL_LSB       = 0;
  localparam int BL_MSB       = 1;
  localparam int BT_BIT       = 3;
  localparam int DLL_RST_BIT  = 8;
  localparam int OTF_ADDR_BIT = 12;
  localparam int DLL_DIS_BIT  = 0;
  localparam int RTT_BIT_LO   = 2;
  localparam int RTT_BIT_MID  = 6;
  localparam int RTT_BIT_HI   = 9;
  localparam int BA_HI_BIT    = 2;

  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  localparam logic [ADDR_W-1:0] MR_RESET   = 13'h0000;
  localparam logic [COL_W-1:0]  BEAT_FIRST = 3'h0;
  localparam logic [COL_W-1:0]  BEAT_LAST  = 3'h7;
  localparam logic [MR_COUNT-1:0] MR_NONE  = 4'h0;

  typedef struct packed {
    logic              cke;
    logic              odt;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } ddrim_pins_t;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic [COL_W-1:0] col;
  } ddrim_beat_t;

  localparam ddrim_pins_t PINS_IDLE = '{cke: 1'b0, odt: 1'b0, cs_n: 1'b1, ras_n: 1'b1,
                                        cas_n: 1'b1, we_n: 1'b1, ba: 3'h0, addr: 13'h0000};
  localparam ddrim_beat_t BEAT_IDLE = '{valid: 1'b0, write: 1'b0, col: 3'h0};

endpackage

// [ddrim_beat_order.sv]
`timescale 1ns/100ps
module ddrim_beat_order
  import ddrim_pkg::*;
#(
  parameter int COL_W_P = COL_W
)
(
  // Burst setup.
  input  wire logic [COL_W_P-1:0] start_in,
  input  wire logic               interleave_in,
  input  wire logic               write_in,
  input  wire logic               chop_in,
  // Beat index and resulting column.
  input  wire logic [COL_W_P-1:0] beat_in,
  output logic      [COL_W_P-1:0] col_out
);

  generate
    if (COL_W_P != 3)
    begin : g_bad_width
      $error("Burst ordering serves three column bits only.");
    end
  endgenerate

  logic [1:0] low_sum;

  assign low_sum = 2'(start_in[1:0] + beat_in[1:0]);

  always_comb
  begin
    if (write_in)
    begin
      if (chop_in)
        col_out = {start_in[2], beat_in[1:0]};
      else
        col_out = beat_in;
    end
    else if (interleave_in)
      col_out = start_in ^ beat_in;
    else
      col_out = {start_in[2] ^ beat_in[2], low_sum};
  end

endmodule // ddrim_beat_order

// [ddrim_core.sv]
`timescale 1ns/100ps
module ddrim_core
  import ddrim_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // Memory pins from the controller.
  input  wire logic        mem_rst_n_in,
  input  wire logic        ck_in,
  input  wire ddrim_pins_t pins_in,
  // Termination and data path.
  output logic             rtt_en_out,
  output logic             dq_oe_out,
  output ddrim_beat_t      beat_out,
  // Mode state.
  output logic [ADDR_W-1:0] burst_latency_mode_reg_out,
  output logic             mr_valid_out,
  output logic             dll_en_out,
  output logic             dll_rst_out
);

  typedef enum logic {BST_IDLE, BST_RUN} ddrim_bst_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic        ck_s1;
  logic        ck_s2;
  logic        ck_prev;
  logic        rst_s1;
  logic        rst_s2;
  ddrim_pins_t pins_s1;
  ddrim_pins_t pins_s2;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ck_s1   <= 1'b0;
      ck_s2   <= 1'b0;
      ck_prev <= 1'b0;
      rst_s1  <= 1'b0;
      rst_s2  <= 1'b0;
      pins_s1 <= PINS_IDLE;
      pins_s2 <= PINS_IDLE;
    end
    else if (clk_en_in)
    begin
      ck_s1   <= ck_in;
      ck_s2   <= ck_s1;
      ck_prev <= ck_s2;
      rst_s1  <= mem_rst_n_in;
      rst_s2  <= rst_s1;
      pins_s1 <= pins_in;
      pins_s2 <= pins_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode on each rising edge of the link clock.

  logic       ck_edge;
  logic       cmd_sel;
  logic       cke_seen;
  logic       is_mrs;
  logic       is_rd;
  logic       is_wr;
  logic [1:0] mr_idx;

  assign ck_edge = ck_s2 & ~ck_prev;
  assign cmd_sel = ck_edge & rst_s2 & cke_seen & ~pins_s2.cs_n;
  assign is_mrs  = cmd_sel & ~pins_s2.ras_n & ~pins_s2.cas_n & ~pins_s2.we_n & ~pins_s2.ba[BA_HI_BIT];
  assign is_rd   = cmd_sel & pins_s2.ras_n & ~pins_s2.cas_n & pins_s2.we_n;
  assign is_wr   = cmd_sel & pins_s2.ras_n & ~pins_s2.cas_n & ~pins_s2.we_n;
  assign mr_idx  = pins_s2.ba[1:0];

  // Termination stays off until CKE is registered high after reset.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      cke_seen <= 1'b0;
    else if (clk_en_in)
    begin
      if (!rst_s2)
        cke_seen <= 1'b0;
      else if (ck_edge && pins_s2.cke)
        cke_seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode registers.

  logic [ADDR_W-1:0]   mode_reg [MR_COUNT];
  logic [MR_COUNT-1:0] mr_written;
  logic [ADDR_W-1:0]   mrs_data;

  always_comb
  begin
    mrs_data = pins_s2.addr;
    if (mr_idx == MR0_IDX)
      mrs_data[DLL_RST_BIT] = 1'b0;
  end

  // Writing a mode register also sets mr_written; MR1 writes update dll_en_out and MR0 writes can pulse dll_rst_out.
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < MR_COUNT; i++)
        mode_reg[i] <= MR_RESET;
      mr_written <= MR_NONE;
    end
    else if (clk_en_in)
    begin
      if (!rst_s2)
        mr_written <= MR_NONE;
      else if (is_mrs)
      begin
        mode_reg[mr_idx]   <= mrs_data;
        mr_written[mr_idx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      dll_rst_out <= 1'b0;
      dll_en_out  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      dll_rst_out <= is_mrs && mr_idx == MR0_IDX && pins_s2.addr[DLL_RST_BIT];
      if (!rst_s2)
        dll_en_out <= 1'b0;
      else if (is_mrs && mr_idx == MR1_IDX)
        dll_en_out <= ~pins_s2.addr[DLL_DIS_BIT];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      mr_valid_out               <= 1'b0;
      burst_latency_mode_reg_out <= MR_RESET;
    end
    else if (clk_en_in)
    begin
      mr_valid_out               <= &mr_written;
      burst_latency_mode_reg_out <= mode_reg[MR0_IDX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // On-die termination.

  logic rtt_nom_on;

  assign rtt_nom_on = mode_reg[MR1_IDX][RTT_BIT_LO] | mode_reg[MR1_IDX][RTT_BIT_MID] |
                      mode_reg[MR1_IDX][RTT_BIT_HI];

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      rtt_en_out <= 1'b0;
    else if (clk_en_in)
      rtt_en_out <= rst_s2 & cke_seen & pins_s2.odt & rtt_nom_on;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst engine.

  ddrim_bst_t       bst_state;
  logic [COL_W-1:0] beat_cnt;
  logic [COL_W-1:0] start_col;
  logic             bst_ilv;
  logic             bst_wr;
  logic             bst_chop;
  logic             next_chop;
  logic             accept;
  logic [COL_W-1:0] order_col;

  assign accept = (is_rd | is_wr) & (bst_state == BST_IDLE);

  always_comb
  begin
    case (mode_reg[MR0_IDX][BL_MSB:BL_LSB])
      BL_FIXED4: next_chop = 1'b1;
      BL_OTF:    next_chop = ~pins_s2.addr[OTF_ADDR_BIT];
      default:   next_chop = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      bst_state <= BST_IDLE;
      beat_cnt  <= BEAT_FIRST;
      start_col <= BEAT_FIRST;
      bst_ilv   <= 1'b0;
      bst_wr    <= 1'b0;
      bst_chop  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (!rst_s2)
        bst_state <= BST_IDLE;
      else
      begin
        case (bst_state)
          BST_IDLE:
          begin
            if (accept)
            begin
              bst_state <= BST_RUN;
              beat_cnt  <= BEAT_FIRST;
              start_col <= pins_s2.addr[COL_W-1:0];
              bst_ilv   <= mode_reg[MR0_IDX][BT_BIT];
              bst_wr    <= is_wr;
              bst_chop  <= next_chop;
            end
          end
          BST_RUN:
          begin
            beat_cnt <= 3'(beat_cnt + 3'h1);
            if (beat_cnt == BEAT_LAST)
              bst_state <= BST_IDLE;
          end
          default:
            bst_state <= BST_IDLE;
        endcase
      end
    end
  end

  ddrim_beat_order #(
    .COL_W_P       (COL_W)
  ) u_order (
    .start_in      (start_col),
    .interleave_in (bst_ilv),
    .write_in      (bst_wr),
    .chop_in       (bst_chop),
    .beat_in       (beat_cnt),
    .col_out       (order_col)
  );

  logic run_now;
  logic slot_used;

  assign run_now   = (bst_state == BST_RUN);
  assign slot_used = ~bst_chop | ~beat_cnt[2];

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      beat_out  <= BEAT_IDLE;
      dq_oe_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      beat_out.valid <= run_now & slot_used;
      beat_out.write <= bst_wr;
      beat_out.col   <= order_col;
      dq_oe_out      <= run_now & ~bst_wr & slot_used;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence reset_pin_seen_s;
    !rst_s2;
  endsequence

  sequence full_burst_s;
    beat_out.valid [*8];
  endsequence

  sequence chop_read_s;
    (dq_oe_out && beat_out.valid) [*4] ##1 (!dq_oe_out && !beat_out.valid) [*4];
  endsequence

  termination_reset_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    reset_pin_seen_s |-> ##1 !rtt_en_out ##1 !cke_seen)
    else $error("Termination active during memory reset.");

  termination_cke_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (!cke_seen && !(ck_edge && pins_s2.cke)) |-> ##1 !rtt_en_out)
    else $error("Termination active before CKE seen high.");

  mrs_target_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (is_mrs && mr_idx == MR2_IDX) |-> ##1 (mr_written[MR2_IDX] && mode_reg[MR2_IDX] == $past(pins_s2.addr)))
    else $error("MRS did not land in the register picked by the bank bits.");

  dll_reset_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (is_mrs && mr_idx == MR0_IDX && pins_s2.addr[DLL_RST_BIT])
      |-> ##1 (dll_rst_out && !mode_reg[MR0_IDX][DLL_RST_BIT]) ##1 !dll_rst_out)
    else $error("DLL reset pulse or self clearing wrong.");

  dll_enable_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (is_mrs && mr_idx == MR1_IDX) |-> ##1 (dll_en_out == !$past(pins_s2.addr[DLL_DIS_BIT])))
    else $error("DLL enable does not follow MR1 bit zero.");

  modes_invalid_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    reset_pin_seen_s |-> ##2 !mr_valid_out)
    else $error("Mode registers reported valid after memory reset.");

  full_burst_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (accept && !next_chop) |-> ##2 full_burst_s ##1 !beat_out.valid)
    else $error("Eight beat burst length wrong.");

  chop_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (accept && is_rd && next_chop) |-> ##2 chop_read_s)
    else $error("Chopped read slots not floated.");

  otf_select_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (accept && mode_reg[MR0_IDX][BL_MSB:BL_LSB] == BL_OTF) |-> ##1 (bst_chop == !$past(pins_s2.addr[OTF_ADDR_BIT])))
    else $error("On-the-fly burst choice ignored A12.");

  seq_half_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (run_now && beat_cnt == 3'h4 && !bst_ilv && !bst_wr) |-> ##1 (beat_out.col == {~start_col[2], start_col[1:0]}))
    else $error("Sequential read second half out of order.");

  ilv_order_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (run_now && bst_ilv && !bst_wr) |-> ##1 (beat_out.col == ($past(start_col) ^ $past(beat_cnt))))
    else $error("Interleaved read order wrong.");

  write_order_a: assert property (@(posedge clk_in) disable iff (sys_rst_in || !clk_en_in)
    (run_now && bst_wr && !bst_chop) |-> ##1 (beat_out.col == $past(beat_cnt) && !dq_oe_out))
    else $error("Eight beat write order not linear.");

endmodule // ddrim_core

// [ddrim_ctrl_model.sv]
`timescale 1ns/100ps
module ddrim_ctrl_model
  import ddrim_pkg::*;
#(
  parameter int GAP_CK = 4,
  parameter int XPR_CK = 5
)
(
  // Requests from the bench.
  input  wire logic        go_in,
  input  wire ddrim_pins_t cmd_in,
  output logic             busy_out,
  // Memory side.
  output logic             ck_out,
  output ddrim_pins_t      pins_out
);
  logic [3:0]  gap    = 4'h0;
  logic        cke_q  = 1'b0;
  logic        busy_q = 1'b0;
  ddrim_pins_t pins_q = PINS_IDLE;

  assign busy_out = busy_q;
  assign pins_out = pins_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Free running command clock, out of phase with the bench clock.
  initial
  begin
    ck_out = 1'b0;
    #13;
    forever #160 ck_out = ~ck_out;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Commands launch on the falling edge and are held for one whole period.
  always @(negedge ck_out)
  begin
    cke_q <= cmd_in.cke;
    if (go_in && !busy_q && gap == 4'h0 && cke_q)
    begin
      pins_q <= cmd_in;
      busy_q <= 1'b1;
      gap    <= 4'(GAP_CK);
    end
    else
    begin
      pins_q.cs_n <= 1'b1;
      pins_q.ba   <= ~pins_q.ba;
      pins_q.addr <= ~pins_q.addr;
      pins_q.cke  <= cmd_in.cke;
      pins_q.odt  <= cmd_in.odt;
      busy_q      <= busy_q & go_in;
      if (cmd_in.cke && !cke_q)
        gap <= 4'(XPR_CK);
      else if (gap != 4'h0)
        gap <= gap - 4'h1;
    end
  end
endmodule // ddrim_ctrl_model

// [test_ddr3_init_mode_register_burst.sv]
`timescale 1ns/100ps
`define CHECK_EQ(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end \
  end
module test_ddr3_init_mode_register_burst;
  import ddrim_pkg::*;
  logic              clk_in     = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              mem_rst_n  = 1'b0;
  logic              go         = 1'b0;
  logic              clk_en     = 1'b1;
  ddrim_pins_t       cmd        = PINS_IDLE;
  ddrim_pins_t       pins;
  ddrim_beat_t       beat;
  logic [ADDR_W-1:0] mode_reg;
  logic              busy, ck, rtt_en, dq_oe, mr_valid, dll_en, dll_rst;
  int                n_mismatch = 0;
  int                compares   = 0;
  int                cycles     = 0;

  always #20 clk_in = ~clk_in;

  ddrim_ctrl_model ddrim_ctrl_model_i (.go_in(go), .cmd_in(cmd), .busy_out(busy), .ck_out(ck), .pins_out(pins));

  ddrim_core ddrim_core_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .mem_rst_n_in(mem_rst_n),
    .ck_in(ck), .pins_in(pins), .rtt_en_out(rtt_en), .dq_oe_out(dq_oe), .beat_out(beat),
    .burst_latency_mode_reg_out(mode_reg), .mr_valid_out(mr_valid), .dll_en_out(dll_en), .dll_rst_out(dll_rst));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic results();
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic send(input logic [2:0] rcw, input logic [2:0] ba, input logic [12:0] addr);
    int k;
    @(negedge clk_in);
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(negedge clk_in);
    if (k == 200) n_mismatch++;
    {cmd.ras_n, cmd.cas_n, cmd.we_n} = rcw;
    cmd.cs_n = 1'b0;
    cmd.ba   = ba;
    cmd.addr = addr;
    go       = 1'b1;
    for (k = 0; k < 200 && busy !== 1'b1; k++) @(negedge clk_in);
    if (k == 200) n_mismatch++;
    go = 1'b0;
  endtask

  task automatic mrs(input logic [2:0] ba, input logic [12:0] addr, output int pulses);
    pulses = 0;
    send(3'b000, ba, addr);
    repeat (16)
    begin
      @(negedge clk_in);
      pulses += int'(dll_rst === 1'b1);
    end
  endtask

  function automatic logic [2:0] exp_col(input logic [2:0] c, input logic [2:0] i, input logic bt,
                                         input logic wr, input logic chop);
    if (wr) return chop ? {c[2], i[1:0]} : i;
    if (bt) return c ^ i;
    return {c[2] ^ i[2], c[1:0] + i[1:0]};
  endfunction

  task automatic burst(input logic wr, input logic [2:0] c, input logic a12, input logic bt, input logic chop);
    int   k;
    logic v;
    send({2'b10, ~wr}, 3'h0, {a12, 9'h000, c});
    for (k = 0; k < 40 && beat.valid !== 1'b1; k++) @(negedge clk_in);
    for (k = 0; k < 8; k++)
    begin
      v = (chop && k > 3) ? 1'b0 : 1'b1;
      `CHECK_EQ("valid", v, beat.valid)
      `CHECK_EQ("dq_oe", v & ~wr, dq_oe)
      if (v)
        `CHECK_EQ("col", exp_col(c, 3'(k), bt, wr, chop), beat.col)
      if (v)
        `CHECK_EQ("write", wr, beat.write)
      @(negedge clk_in);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic test_reset_state();
    cmd.odt = 1'b1;
    tick(6);
    `CHECK_EQ("rtt_reset", 1'b0, rtt_en)
    `CHECK_EQ("beat_reset", BEAT_IDLE, beat)
    `CHECK_EQ("valid_reset", 1'b0, mr_valid)
    cmd.odt = 1'b0;
  endtask

  task automatic test_init_sequence();
    int p;
    mem_rst_n = 1'b1;
    tick(4);
    cmd.cke = 1'b1;
    mrs(3'h2, 13'h0008, p);
    `CHECK_EQ("valid_mr2", 1'b0, mr_valid)
    mrs(3'h3, 13'h0000, p);
    `CHECK_EQ("valid_mr3", 1'b0, mr_valid)
    mrs(3'h1, 13'h0044, p);
    `CHECK_EQ("dll_en", 1'b1, dll_en)
    `CHECK_EQ("valid_mr1", 1'b0, mr_valid)
    mrs(3'h0, 13'h0D30, p);
    `CHECK_EQ("dll_rst", 1, p)
    `CHECK_EQ("mode_mr0", 13'h0C30, mode_reg)
    `CHECK_EQ("valid_mr0", 1'b1, mr_valid)
    send(3'b110, 3'h0, 13'h0400);
    tick(64);
    `CHECK_EQ("zq_ignored", 13'h0C30, mode_reg)
    `CHECK_EQ("valid_zq", 1'b1, mr_valid)
    mrs(3'h4, 13'h0003, p);
    `CHECK_EQ("mode_ba2", 13'h0C30, mode_reg)
    mrs(3'h1, 13'h0045, p);
    `CHECK_EQ("dll_off", 1'b0, dll_en)
    mrs(3'h1, 13'h0044, p);
    `CHECK_EQ("dll_on", 1'b1, dll_en)
  endtask

  task automatic test_burst_modes();
    logic [3:0]  modes [7] = '{4'b0000, 4'b1000, 4'b0100, 4'b1100, 4'b0010, 4'b1011, 4'b0111};
    logic [12:0] a;
    logic        chop;
    int          p;
    foreach (modes[m])
    begin
      a    = {9'h000, modes[m][3], 1'b0, modes[m][2:1]};
      chop = (modes[m][2:1] == 2'b10) || (modes[m][2:1] == 2'b01 && !modes[m][0]);
      mrs(3'h0, a, p);
      `CHECK_EQ("mode_burst", a, mode_reg)
      `CHECK_EQ("dll_rst_none", 0, p)
      for (int c = 0; c < 8; c++)
        burst(1'b0, 3'(c), modes[m][0], modes[m][3], chop);
      burst(1'b1, 3'h6, modes[m][0], modes[m][3], chop);
      burst(1'b1, 3'h1, modes[m][0], modes[m][3], chop);
    end
  endtask

  task automatic test_termination();
    clk_en  = 1'b0;
    cmd.odt = 1'b1;
    tick(12);
    `CHECK_EQ("rtt_frozen", 1'b0, rtt_en)
    `CHECK_EQ("valid_frozen", 1'b1, mr_valid)
    clk_en  = 1'b1;
    tick(12);
    `CHECK_EQ("rtt_on", 1'b1, rtt_en)
    mem_rst_n = 1'b0;
    cmd.cke   = 1'b0;
    tick(8);
    `CHECK_EQ("rtt_rst", 1'b0, rtt_en)
    `CHECK_EQ("valid_rst", 1'b0, mr_valid)
    `CHECK_EQ("dll_en_rst", 1'b0, dll_en)
    mem_rst_n = 1'b1;
    tick(40);
    `CHECK_EQ("rtt_nocke", 1'b0, rtt_en)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    test_reset_state();
    test_init_sequence();
    test_burst_modes();
    test_termination();
    results();
  end
endmodule // test_ddr3_init_mode_register_burst
